/* design/rtb_pkg.sv */
// Purpose: Constants and types for the indirect-access real-time counter
// Assumes: One 10 MHz system clock, oscillator ticks arrive as inputs
// Notes:   Internal register indices are the block's own layout
package rtb_pkg;
  // Special-function addresses of the two host registers
  localparam logic [7:0] ADDR_REG_OFS  = 8'hac;
  localparam logic [7:0] DATA_REG_OFS  = 8'had;
  // Field positions in the indirect address register
  localparam int         BUSY_BIT      = 7;
  localparam int         AUTO_BIT      = 6;
  localparam int         UNUSED_BIT    = 5;
  localparam int         SHORT_BIT     = 4;
  localparam logic [7:0] ADDR_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  // Internal register indices
  localparam logic [3:0] IX_CAPTURE0   = 4'h0;
  localparam logic [3:0] IX_CAPTURE3   = 4'h3;
  localparam logic [3:0] IX_CONTROL    = 4'h4;
  localparam logic [3:0] IX_OSC_CTRL   = 4'h5;
  localparam logic [3:0] IX_LOAD_CAP   = 4'h6;
  localparam logic [3:0] IX_EVT_CFG    = 4'h7;
  localparam logic [3:0] IX_ALARM0     = 4'h8;
  localparam logic [3:0] IX_ALARM3     = 4'hb;
  // Control register field positions
  localparam int         CTL_RUN       = 0;
  localparam int         CTL_SNAP      = 1;
  localparam int         CTL_SET       = 2;
  localparam int         CTL_ALM_EN    = 3;
  localparam int         CTL_ALM_FLAG  = 4;
  localparam int         CTL_MISS_FLAG = 5;
  localparam int         CTL_CLKOUT    = 6;
  localparam int         CTL_MISS_EN   = 7;
  // Oscillator control field positions
  localparam int         OSC_CRYSTAL_MODE_SELECT     = 0;
  localparam int         OSC_BIAS      = 1;
  localparam int         OSC_LFO       = 2;
  // Event config: bit0 alarm->reset, bit1 missing->reset
  localparam int         EVT_ALM_RST   = 0;
  localparam int         EVT_MISS_RST  = 1;
  // Transfer latency in system cycles, normal and short strobe
  localparam logic [2:0] XFER_LONG     = 3'h4;
  localparam logic [2:0] XFER_SHORT    = 3'h1;
  // Missing-oscillator timeout in microseconds and derived cycles
  localparam int         CLK_MHZ       = 10;
  localparam int         MISS_US       = 1000;
  localparam int         MISS_CYC      = MISS_US * CLK_MHZ;
  // Indirect interface state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } rtb_state_e;
  // Host bus request bundle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtb_req_s;
endpackage : rtb_pkg

/* design/rtb_timebase.sv */
// Purpose: 32-bit real-time counter with alarm behind indirect registers
// Assumes: Oscillator ticks are one-cycle pulses synchronous to I_CLK
// Notes:   Pins osc_pin_a/b and analog oscillator are modelled as controls
//
// Functional notes
// - 32-bit free-running counter with alarm compare
// - Sixteen-level load capacitance field
// - Counter keeps running in power-down
// - Oscillator buffered out to a pin
// - Alarm and missing events, wake or reset
// - Bit 7 busy; writing 1 starts read
// - Bit 5 unused, reads zero
// - Bit 4 enables short strobe
// - Low four bits select internal register
// - Auto-increment after snapshot or alarm access
// - Data register carries selected byte
// - Crystal select zero shorts oscillator pins unless low-freq osc selected
// - Bias select picks 20 or 40 kHz
// - Low-freq enable selects internal oscillator
// - Low-freq ticks increment at bit 1
// - Low-freq oscillator about 16.4 kHz, no parts
`timescale 1ns/1ps
`default_nettype none
module rtb_timebase
  import rtb_pkg::*;
#(
  parameter int MISS_CYCLES = MISS_CYC  // Missing-clock timeout
) (
  input  wire logic       I_CLK,        // System clock
  input  wire logic       I_NRST,       // Synchronous reset, active low
  input  wire rtb_req_s   I_REQ,        // Host register access
  input  wire logic       I_XTAL_TICK,  // Crystal/self-osc tick
  input  wire logic       I_LFO_TICK,   // Internal low-freq osc tick
  input  wire logic       I_PWR_DOWN,   // Deepest power-down active
  output logic [7:0]      O_RDATA,      // Host read data
  output logic            O_OSC_OUT,    // Buffered oscillator to pin
  output logic            O_PIN_SHORT,  // Oscillator pins joined
  output logic            O_BIAS_X2,    // Bias doubling select
  output logic            O_LFO_ON,     // Internal osc enable
  output logic [3:0]      O_LOAD_CAP,   // Load capacitance level
  output logic            O_WAKE,       // Wake request pulse
  output logic            O_RESET_REQ   // Reset request pulse
);
  // Host register state
  logic [7:0]  adr;                     // Indirect address register
  logic [7:0]  dat;                     // Indirect data register
  rtb_state_e  state;                   // Interface state
  logic [2:0]  wait_cnt;                // Transfer latency counter
  // Internal registers
  logic [31:0] count;                   // Time-keeping counter
  logic [31:0] snap;                    // Snapshot of counter
  logic [31:0] alarm;                   // Alarm compare value
  logic [7:0]  ctl;                     // Control byte
  logic [7:0]  osc;                     // Oscillator control byte
  logic [7:0]  cap;                     // Load cap byte
  logic [7:0]  evt;                     // Event routing byte
  logic [$clog2(MISS_CYCLES+1)-1:0] miss_cnt; // Ticks-absent counter
  logic        osc_q;                   // Output toggle
  // Decoded helpers
  logic        sel_lfo;                 // Low-freq source selected
  logic        tick;                    // Source tick this cycle
  logic        alarm_hit;               // Compare match event
  logic        miss_hit;                // Missing-clock event
  logic        autoinc;                 // Address targets snap/alarm
  logic        wr_adr;                  // Host writes address reg
  logic        wr_dat;                  // Host writes data reg
  logic [7:0]  rd_byte;                 // Internal read mux
  logic [1:0]  lane;                    // Byte lane in 32-bit regs

  assign sel_lfo  = osc[OSC_LFO];
  assign tick     = sel_lfo ? I_LFO_TICK : I_XTAL_TICK;
  assign wr_adr   = I_REQ.wr && (I_REQ.addr == ADDR_REG_OFS);
  assign wr_dat   = I_REQ.wr && (I_REQ.addr == DATA_REG_OFS);
  assign lane     = adr[1:0];
  assign autoinc  = (adr[3:0] <= IX_CAPTURE3) ||
                    (adr[3:0] >= IX_ALARM0 && adr[3:0] <= IX_ALARM3);
  assign alarm_hit = ctl[CTL_ALM_EN] && tick && (count == alarm);
  assign miss_hit  = ctl[CTL_MISS_EN] &&
                     (miss_cnt == MISS_CYCLES[$bits(miss_cnt)-1:0]);

  // Internal register read mux
  always_comb begin
    rd_byte = 8'h00;
    if (adr[3:0] <= IX_CAPTURE3) begin
      rd_byte = snap[lane*8 +: 8];
    end else if (adr[3:0] >= IX_ALARM0 && adr[3:0] <= IX_ALARM3) begin
      rd_byte = alarm[lane*8 +: 8];
    end else begin
      unique case (adr[3:0])
        IX_CONTROL:  rd_byte = ctl;
        IX_OSC_CTRL: rd_byte = osc;
        IX_LOAD_CAP: rd_byte = cap;
        IX_EVT_CFG:  rd_byte = evt;
        default:     rd_byte = 8'h00;   // Unmapped index
      endcase
    end
  end

  // Host read data, registered
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_RDATA <= 8'h00;
    end else if (I_REQ.rd) begin
      if (I_REQ.addr == ADDR_REG_OFS) begin
        O_RDATA <= {state != ST_IDLE, adr[6], 1'b0, adr[4:0]};
      end else if (I_REQ.addr == DATA_REG_OFS) begin
        O_RDATA <= dat;
      end else begin
        O_RDATA <= 8'h00;               // Not ours
      end
    end
  end

  // Indirect interface sequencer
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      state    <= ST_IDLE;
      wait_cnt <= 3'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // A start written with the address takes its own strobe length
          wait_cnt <= (wr_adr ? I_REQ.wdata[SHORT_BIT] : adr[SHORT_BIT])
                      ? XFER_SHORT : XFER_LONG;
          if (wr_adr && I_REQ.wdata[BUSY_BIT]) begin
            state <= ST_READ;
          end else if (wr_dat) begin
            state <= ST_WRITE;
          end
        end
        ST_READ, ST_WRITE: begin
          if (wait_cnt == 3'h1) begin
            state <= ST_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 3'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Address and data registers
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      adr <= ADDR_RESET;
      dat <= DATA_RESET;
    end else if (state == ST_IDLE) begin
      if (wr_adr) begin
        adr <= {1'b0, I_REQ.wdata[AUTO_BIT], 1'b0,
                I_REQ.wdata[SHORT_BIT:0]};
      end
      if (wr_dat) begin
        dat <= I_REQ.wdata;
      end
    end else if (wait_cnt == 3'h1) begin
      if (state == ST_READ) begin
        dat <= rd_byte;
      end
      if (autoinc) begin
        adr[3:0] <= adr[3:0] + 4'h1;
      end
    end
  end

  // Internal register writes at transfer end
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      alarm <= 32'h0000_0000;
      ctl   <= 8'h00;
      osc   <= 8'h00;
      cap   <= 8'h00;
      evt   <= 8'h00;
    end else begin
      if (state == ST_WRITE && wait_cnt == 3'h1) begin
        if (adr[3:0] >= IX_ALARM0 && adr[3:0] <= IX_ALARM3) begin
          alarm[lane*8 +: 8] <= dat;
        end
        unique case (adr[3:0])
          IX_CONTROL:  ctl <= dat;
          IX_OSC_CTRL: osc <= dat;
          IX_LOAD_CAP: cap <= dat;
          IX_EVT_CFG:  evt <= dat;
          default:     ;
        endcase
      end else begin
        ctl[CTL_SNAP] <= 1'b0;          // Strobes self-clear
        ctl[CTL_SET]  <= 1'b0;
      end
      if (alarm_hit) begin
        ctl[CTL_ALM_FLAG] <= 1'b1;      // Set wins over clear
      end
      if (miss_hit) begin
        ctl[CTL_MISS_FLAG] <= 1'b1;
      end
    end
  end

  // Counter, runs regardless of power-down
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      count <= 32'h0000_0000;
      snap  <= 32'h0000_0000;
    end else begin
      if (ctl[CTL_SET]) begin
        count <= snap;
      end else if (ctl[CTL_RUN] && tick) begin
        count <= count + (sel_lfo ? 32'h2 : 32'h1);
      end
      if (ctl[CTL_SNAP]) begin
        snap <= count;
      end else if (state == ST_WRITE && wait_cnt == 3'h1 &&
                   adr[3:0] <= IX_CAPTURE3) begin
        snap[lane*8 +: 8] <= dat;
      end
    end
  end

  // Missing-oscillator watchdog
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      miss_cnt <= '0;
    end else if (tick || !ctl[CTL_MISS_EN] || miss_hit) begin
      miss_cnt <= '0;
    end else begin
      miss_cnt <= miss_cnt + 1'b1;
    end
  end

  // Oscillator controls, buffered output and event routing
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      osc_q       <= 1'b0;
      O_OSC_OUT   <= 1'b0;
      O_PIN_SHORT <= 1'b0;
      O_BIAS_X2   <= 1'b0;
      O_LFO_ON    <= 1'b0;
      O_LOAD_CAP  <= 4'h0;
      O_WAKE      <= 1'b0;
      O_RESET_REQ <= 1'b0;
    end else begin
      if (tick) begin
        osc_q <= ~osc_q;
      end
      O_OSC_OUT   <= ctl[CTL_CLKOUT] & osc_q;
      O_PIN_SHORT <= ~osc[OSC_CRYSTAL_MODE_SELECT] & ~sel_lfo;
      O_BIAS_X2   <= osc[OSC_BIAS];
      O_LFO_ON    <= sel_lfo;
      O_LOAD_CAP  <= cap[3:0];
      O_WAKE      <= I_PWR_DOWN &
                     ((alarm_hit & ~evt[EVT_ALM_RST]) |
                      (miss_hit & ~evt[EVT_MISS_RST]));
      O_RESET_REQ <= (alarm_hit & evt[EVT_ALM_RST]) |
                     (miss_hit & evt[EVT_MISS_RST]);
    end
  end
endmodule : rtb_timebase
`default_nettype wire

/* dv/rtb_monitor.sv */
// Purpose: Port-level checks of the indirect real-time counter
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module rtb_monitor
  import rtb_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_NRST,
  input wire rtb_req_s   I_REQ,
  input wire logic       I_XTAL_TICK,
  input wire logic       I_LFO_TICK,
  input wire logic [7:0] O_RDATA,
  input wire logic       O_OSC_OUT,
  input wire logic       O_PIN_SHORT,
  input wire logic       O_BIAS_X2,
  input wire logic       O_LFO_ON,
  input wire logic [3:0] O_LOAD_CAP,
  input wire logic       O_WAKE,
  input wire logic       O_RESET_REQ
);
  logic [3:0] since_wr;  // Cycles since last host write
  // Saturating age of the last write
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) since_wr <= 4'hf;
    else if (I_REQ.wr) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // Address write that starts an indirect read
  sequence s_start;
    I_REQ.wr && I_REQ.addr == ADDR_REG_OFS && I_REQ.wdata[BUSY_BIT];
  endsequence
  // Plain read of the address register
  sequence s_rd_adr;
    I_REQ.rd && I_REQ.addr == ADDR_REG_OFS;
  endsequence
  a_rdata_holds: assert property (
    !I_REQ.rd |=> $stable(O_RDATA)) else $error("read data moved");
  a_unused_zero: assert property (
    s_rd_adr |=> !O_RDATA[UNUSED_BIT]) else $error("unused bit set");
  a_busy_set: assert property (
    (s_start ##0 !I_REQ.wdata[SHORT_BIT]) ##2 s_rd_adr |=>
    O_RDATA[BUSY_BIT]) else $error("busy not shown");
  a_busy_clear: assert property (
    s_start ##6 s_rd_adr |=> !O_RDATA[BUSY_BIT])
    else $error("busy stuck");
  a_wake_pulse: assert property (
    O_WAKE |=> !O_WAKE) else $error("wake too long");
  a_rst_pulse: assert property (
    O_RESET_REQ |=> !O_RESET_REQ) else $error("reset req too long");
  a_osc_cause: assert property (
    $changed(O_OSC_OUT) |-> $past(I_XTAL_TICK || I_LFO_TICK) ||
    $past(I_XTAL_TICK || I_LFO_TICK, 2)) else $error("osc out moved");
  a_lfo_noshort: assert property (
    O_LFO_ON |-> !O_PIN_SHORT) else $error("pins shorted on lfo");
  a_cfg_cause: assert property (
    $changed({O_BIAS_X2, O_LFO_ON, O_LOAD_CAP}) |-> since_wr <= 4'h6)
    else $error("config moved without write");
endmodule : rtb_monitor
`default_nettype wire

/* dv/rtb_timebase_tb.sv */
// Purpose: Self-checking bench of the indirect real-time counter
// Assumes: Inputs driven at the falling edge
// Notes:   Missing-clock timeout shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module rtb_timebase_tb;
  import rtb_pkg::*;
  logic       clk  = 1'b0;  // System clock
  logic       nrst = 1'b0;  // Reset, active low
  rtb_req_s   req  = '0;    // Host access
  logic       xt   = 1'b0;  // Crystal tick
  logic       lt   = 1'b0;  // Low-freq tick
  logic       pd   = 1'b1;  // Power-down held on until t_miss
  logic [7:0] rdata, v;
  logic [3:0] lcap;
  logic       osc, psh, bx2, lon, wake, rreq;
  int n_errors = 0;
  int checks_done = 0;
  int n_wake = 0;
  int n_rreq = 0;
  always #50 clk = ~clk;
  rtb_timebase #(.MISS_CYCLES(20)) DUT (.I_CLK(clk), .I_NRST(nrst),
    .I_REQ(req), .I_XTAL_TICK(xt), .I_LFO_TICK(lt), .I_PWR_DOWN(pd),
    .O_RDATA(rdata), .O_OSC_OUT(osc), .O_PIN_SHORT(psh), .O_BIAS_X2(bx2),
    .O_LFO_ON(lon), .O_LOAD_CAP(lcap), .O_WAKE(wake), .O_RESET_REQ(rreq));
  // Event pulse counters
  always @(posedge clk) begin
    if (wake === 1'b1) n_wake++;
    if (rreq === 1'b1) n_rreq++;
  end
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // One host cycle, entered at a falling edge
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    v = rdata;
    @(negedge clk);
  endtask : bus
  task automatic wait_idle;
    for (int i = 0; i < 20; i++) begin
      bus(1'b0, ADDR_REG_OFS, 8'h00);
      if (v[BUSY_BIT] === 1'b0) break;
    end
    chk("busy", {7'h0, v[BUSY_BIT]}, 8'h00);
  endtask : wait_idle
  task automatic iwr(logic [3:0] ix, logic [7:0] d);
    bus(1'b1, ADDR_REG_OFS, {4'h0, ix});
    bus(1'b1, DATA_REG_OFS, d);
    wait_idle();
  endtask : iwr
  task automatic ird(logic [7:0] a, logic [7:0] exp);
    bus(1'b1, ADDR_REG_OFS, a);
    wait_idle();
    bus(1'b0, DATA_REG_OFS, 8'h00);
    chk("idata", v, exp);
  endtask : ird
  task automatic tick(logic lf, int n);
    repeat (n) begin
      {lt, xt} = {lf, !lf};
      @(negedge clk);
      {lt, xt} = 2'b00;
      @(negedge clk);
    end
  endtask : tick
  task automatic t_regs;
    bus(1'b0, ADDR_REG_OFS, 8'h00);
    chk("adr_rst", v, ADDR_RESET);
    bus(1'b0, DATA_REG_OFS, 8'h00);
    chk("dat_rst", v, DATA_RESET);
    bus(1'b1, ADDR_REG_OFS, 8'h3a);
    bus(1'b0, ADDR_REG_OFS, 8'h00);
    chk("adr_bits", v, 8'h1a);
  endtask : t_regs
  task automatic t_cfg;
    iwr(IX_LOAD_CAP, 8'h0f);
    chk("cap", {4'h0, lcap}, 8'h0f);
    iwr(IX_OSC_CTRL, 8'h02);
    chk("self", {psh, bx2, lon}, 8'h06);
    iwr(IX_OSC_CTRL, 8'h04);
    chk("lfo", {psh, bx2, lon}, 8'h01);
    // Short strobe: done before the first poll
    bus(1'b1, ADDR_REG_OFS, 8'h90 | {4'h0, IX_LOAD_CAP});
    bus(1'b0, ADDR_REG_OFS, 8'h00);
    chk("short", v, 8'h16);
    bus(1'b0, DATA_REG_OFS, 8'h00);
    chk("idata", v, 8'h0f);
    iwr(IX_OSC_CTRL, 8'h01);
  endtask : t_cfg
  task automatic t_count;
    iwr(IX_CONTROL, 8'h41);
    tick(1'b0, 5);
    chk("osc", {7'h0, osc}, 8'h01);
    iwr(IX_CONTROL, 8'h43);
    bus(1'b0, ADDR_REG_OFS, 8'h00);
    chk("no_inc", v, 8'h04);
    ird(8'h80 | IX_CAPTURE0, 8'h05);
    bus(1'b0, ADDR_REG_OFS, 8'h00);
    chk("inc", v, 8'h01);
    iwr(IX_OSC_CTRL, 8'h04);
    tick(1'b1, 3);
    iwr(IX_CONTROL, 8'h43);
    ird(8'h80 | IX_CAPTURE0, 8'h0b);
  endtask : t_count
  task automatic t_alarm;
    iwr(IX_OSC_CTRL, 8'h01);
    bus(1'b1, ADDR_REG_OFS, {4'h0, IX_ALARM0});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, DATA_REG_OFS, (i == 0) ? 8'h0e : 8'h00);
      wait_idle();
    end
    chk("alm_inc", v, 8'h0c);
    iwr(IX_CONTROL, 8'h09);
    n_wake = 0;
    tick(1'b0, 5);
    chk("wake", 8'(n_wake), 8'h01);
    iwr(IX_EVT_CFG, 8'h01);
    iwr(IX_ALARM0, 8'h12);
    n_rreq = 0;
    tick(1'b0, 5);
    chk("rreq", 8'(n_rreq), 8'h01);
    chk("wake2", 8'(n_wake), 8'h01);
  endtask : t_alarm
  // Load the counter from the snapshot, then read it back
  task automatic t_set;
    bus(1'b1, ADDR_REG_OFS, {4'h0, IX_CAPTURE0});
    bus(1'b1, DATA_REG_OFS, 8'h40);
    wait_idle();
    iwr(IX_CONTROL, 8'h05);
    iwr(IX_CONTROL, 8'h03);
    ird(8'h80 | IX_CAPTURE0, 8'h40);
  endtask : t_set
  // Missing-clock events: wake, gating by power-down, reset routing
  task automatic t_miss;
    iwr(IX_CONTROL, 8'h81);
    n_wake = 0;
    repeat (21) @(negedge clk);
    chk("miss_wake", 8'(n_wake), 8'h01);
    ird(8'h80 | IX_CONTROL, 8'ha1);
    pd = 1'b0;
    @(negedge clk);
    n_wake = 0;
    repeat (21) @(negedge clk);
    chk("pd_gate", 8'(n_wake), 8'h00);
    iwr(IX_EVT_CFG, 8'h02);
    n_rreq = 0;
    repeat (21) @(negedge clk);
    chk("miss_rreq", 8'(n_rreq), 8'h01);
  endtask : t_miss
  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    #(20000 * 100);
    n_errors++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_cfg();
    t_count();
    t_alarm();
    t_set();
    t_miss();
    final_report();
  end
endmodule : rtb_timebase_tb
bind rtb_timebase rtb_monitor u_mon (.*);
`default_nettype wire
